// [verilog/spm_pkg.sv]
// Package: register map, field layout and carrier types of the pin mux
package spm_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_D_FSEL   = 8'h00;
   localparam logic [7:0] OFS_D_DIR    = 8'h04;
   localparam logic [7:0] OFS_D_DATA   = 8'h08;
   localparam logic [7:0] OFS_E_FSEL   = 8'h0c;
   localparam logic [7:0] OFS_E_DIR    = 8'h10;
   localparam logic [7:0] OFS_E_DATA   = 8'h14;
   localparam logic [7:0] OFS_CTRL     = 8'h18;
   localparam logic [7:0] OFS_STATUS   = 8'h1c;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] RST_FSEL     = 3'h0;
   localparam logic [2:0] RST_DIR      = 3'h0;
   localparam logic [2:0] RST_DATA     = 3'h0;
   localparam logic [4:0] RST_CTRL     = 5'h00;

   // ----------------------------------------------------------------
   // Pin positions within each three-pin port
   // ----------------------------------------------------------------
   localparam int PIN_D_CLK  = 0;
   localparam int PIN_D_RX   = 1;
   localparam int PIN_D_TX   = 2;
   localparam int PIN_E_RX   = 0;
   localparam int PIN_E_TX   = 1;
   localparam int PIN_E_CLK  = 2;

   // ----------------------------------------------------------------
   // Control and status field positions
   // ----------------------------------------------------------------
   localparam int CTRL_SYNC_MODE   = 0;
   localparam int CTRL_SCLK_OUT    = 1;
   localparam int CTRL_ACLK_OUT    = 2;
   localparam int CTRL_ACLK_TX     = 3;
   localparam int CTRL_ACLK_RX     = 4;
   localparam int STAT_VIOL        = 0;
   localparam int STAT_D_LVL       = 8;
   localparam int STAT_E_LVL       = 12;

   // ----------------------------------------------------------------
   // Timing counts in system clock cycles
   // ----------------------------------------------------------------
   localparam int MIN_HALF_CYCLES  = 3;
   localparam int MIN_PERIOD_CYCLES = 2 * MIN_HALF_CYCLES;
   localparam int HALF_W = $clog2(MIN_HALF_CYCLES + 1);

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] o;
      logic [2:0] oe;
   } spm_pins_type;

   typedef struct packed {
      logic tx_bit;
      logic tx_active;
      logic clk_gen;
   } spm_sync_in_type;

   typedef struct packed {
      logic rx_bit;
      logic tx_shift;
      logic rx_sample;
   } spm_sync_out_type;

   typedef struct packed {
      logic tx_bit;
      logic clk_gen;
   } spm_async_in_type;

   typedef struct packed {
      logic rx_bit;
      logic tx_tick;
      logic rx_tick;
   } spm_async_out_type;

endpackage

// [verilog/spm_sync2.sv]
// Two-stage synchroniser for pin levels entering the pclk domain
`timescale 1ns/1ns
module spm_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   // ----------------------------------------------------------------
   // First stage is read only by the second
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // spm_sync2

// [verilog/spm_pin_mux.sv]
// Pin mux for the sync and async serial units with APB registers
// Function
// - Reset leaves all six serial pins as general-purpose lines.
// - Port D select picks serial role or GPIO per sync pin.
// - Port E select picks serial role or GPIO per async pin.
// - Port D GPIO pin direction follows port D direction bit.
// - Sync bit clock drives tx and rx in sync mode, tx only else.
// - Each sync clock half lasts at least three system cycles.
// - Sync receive pin in serial role is input to the sync unit.
// - Sync transmit pin drives tx data, output only while sending.
// - Async receive pin feeds serial data to the async unit.
// - Async transmit pin outputs async unit transmit data.
// - Async clock pin is input or output, for tx, rx or both.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module spm_pin_mux
   import spm_pkg::*;
(
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [2:0]                  port_d_pin_i,
   output spm_pkg::spm_pins_type            port_d_pin,
   input  wire logic [2:0]                  port_e_pin_i,
   output spm_pkg::spm_pins_type            port_e_pin,
   input  wire spm_pkg::spm_sync_in_type    sync_unit_i,
   output spm_pkg::spm_sync_out_type        sync_unit_o,
   input  wire spm_pkg::spm_async_in_type   async_unit_i,
   output spm_pkg::spm_async_out_type       async_unit_o
);
   import spm_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      // Software-visible registers
      logic [2:0]        d_fsel;
      logic [2:0]        d_dir;
      logic [2:0]        d_data;
      logic [2:0]        e_fsel;
      logic [2:0]        e_dir;
      logic [2:0]        e_data;
      logic [4:0]        ctrl;

      // Clock watch and edge history
      logic              viol;
      logic              sclk_prev;
      logic              sclk_armed;
      logic [HALF_W-1:0] half_cnt;
      logic              aclk_prev;

      // Bus answer
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;

      // Registered pin drive and unit strobes
      spm_pins_type      d_pin;
      spm_pins_type      e_pin;
      spm_sync_out_type  sync_o;
      spm_async_out_type async_o;
   } spm_state_type;

   spm_state_type state_q;
   spm_state_type state_d;

   logic [2:0] d_lvl;
   logic [2:0] e_lvl;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Two flops per pin; the logic never sees a raw pin level
   spm_sync2 #(
      .WIDTH    (3)
   ) u_sync_d (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (port_d_pin_i),
      .sync_out (d_lvl)
   );

   spm_sync2 #(
      .WIDTH    (3)
   ) u_sync_e (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (port_e_pin_i),
      .sync_out (e_lvl)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic              wr_en;
      logic              rd_en;
      logic              hit;
      logic [31:0]       rdata;
      logic              sync_mode;
      logic              sclk_lvl;
      logic              sclk_rise;
      logic              sclk_fall;
      logic              sclk_edge;
      logic              viol_set;
      logic              viol_clr;
      logic              aclk_lvl;
      logic              aclk_rise;
      logic [HALF_W-1:0] half_max;

      state_d   = state_q;
      wr_en     = 1'b0;
      rd_en     = 1'b0;
      hit       = 1'b1;
      rdata     = 32'h0000_0000;
      sync_mode = state_q.ctrl[CTRL_SYNC_MODE];
      half_max  = HALF_W'(MIN_HALF_CYCLES);
      viol_set  = 1'b0;
      viol_clr  = 1'b0;
      sclk_lvl  = 1'b0;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      sclk_edge = 1'b0;
      aclk_lvl  = 1'b0;
      aclk_rise = 1'b0;

      // ----------------------------------------------------------------
      // Register bus
      // ----------------------------------------------------------------
      // APB: one wait state, pready raised for one cycle
      rd_en = psel && penable && !state_q.pready;
      wr_en = psel && penable && pwrite && state_q.pready;

      // Read mux; an unmapped offset answers with an error
      case (paddr)
         OFS_D_FSEL: begin
            rdata[2:0] = state_q.d_fsel;
         end
         OFS_D_DIR: begin
            rdata[2:0] = state_q.d_dir;
         end
         OFS_D_DATA: begin
            rdata[2:0] = d_lvl;
         end
         OFS_E_FSEL: begin
            rdata[2:0] = state_q.e_fsel;
         end
         OFS_E_DIR: begin
            rdata[2:0] = state_q.e_dir;
         end
         OFS_E_DATA: begin
            rdata[2:0] = e_lvl;
         end
         OFS_CTRL: begin
            rdata[4:0] = state_q.ctrl;
         end
         OFS_STATUS: begin
            rdata[STAT_VIOL]              = state_q.viol;
            rdata[STAT_D_LVL +: 3]        = d_lvl;
            rdata[STAT_E_LVL +: 3]        = e_lvl;
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      state_d.pready = rd_en;
      if (rd_en) begin
         state_d.prdata  = pwrite ? 32'h0000_0000 : rdata;
         state_d.pslverr = !hit;
      end else begin
         state_d.prdata  = 32'h0000_0000;
         state_d.pslverr = 1'b0;
      end

      // A write lands at the edge that sees pready high, while the
      // master still holds address and data
      if (wr_en && hit) begin
         case (paddr)
            OFS_D_FSEL: state_d.d_fsel = pwdata[2:0];
            OFS_D_DIR:  state_d.d_dir  = pwdata[2:0];
            OFS_D_DATA: state_d.d_data = pwdata[2:0];
            OFS_E_FSEL: state_d.e_fsel = pwdata[2:0];
            OFS_E_DIR:  state_d.e_dir  = pwdata[2:0];
            OFS_E_DATA: state_d.e_data = pwdata[2:0];
            OFS_CTRL:   state_d.ctrl   = pwdata[4:0];
            OFS_STATUS: viol_clr       = pwdata[STAT_VIOL];
            default: begin
               viol_clr = 1'b0;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // Serial clock edges
      // ----------------------------------------------------------------
      // Sync bit clock: own generated clock when driving the pin,
      // else the synchronised pin level
      // Changing the clock source mid-frame can show one false edge,
      // so software switches it only while the link is idle
      if (state_q.ctrl[CTRL_SCLK_OUT]) begin
         sclk_lvl = sync_unit_i.clk_gen;
      end else begin
         sclk_lvl = d_lvl[PIN_D_CLK];
      end
      sclk_rise = sclk_lvl && !state_q.sclk_prev;
      sclk_fall = !sclk_lvl && state_q.sclk_prev;
      sclk_edge = sclk_rise || sclk_fall;
      state_d.sclk_prev = sclk_lvl;

      // Half-period watch; first half after selection is unarmed
      // Pin clock halves are timed on the synchronised level, so a half that
      // only just meets the limit may still be flagged
      if (!state_q.d_fsel[PIN_D_CLK]) begin
         state_d.sclk_armed = 1'b0;
         state_d.half_cnt   = '0;
      end else if (sclk_edge) begin
         // Too fast a clock is flagged, and its edges are still served
         viol_set           = state_q.sclk_armed &&
                              (state_q.half_cnt < half_max);
         state_d.sclk_armed = 1'b1;
         state_d.half_cnt   = HALF_W'(1);
      end else if (state_q.half_cnt < half_max) begin
         state_d.half_cnt   = state_q.half_cnt + HALF_W'(1);
      end

      // Set wins over a write-one clear in the same cycle
      if (viol_set) begin
         state_d.viol = 1'b1;
      end else if (viol_clr) begin
         state_d.viol = 1'b0;
      end

      // Clock serves tx always, rx only in sync mode
      state_d.sync_o.tx_shift  = state_q.d_fsel[PIN_D_CLK] && sclk_rise;
      state_d.sync_o.rx_sample = state_q.d_fsel[PIN_D_CLK] && sclk_fall &&
                                 sync_mode;
      // Receive data into the sync unit
      state_d.sync_o.rx_bit    = state_q.d_fsel[PIN_D_RX] &&
                                 d_lvl[PIN_D_RX];

      // Async clock edges, steered to tx and/or rx
      // Rising edges only; the unit times its bits from these ticks
      if (state_q.ctrl[CTRL_ACLK_OUT]) begin
         aclk_lvl = async_unit_i.clk_gen;
      end else begin
         aclk_lvl = e_lvl[PIN_E_CLK];
      end
      aclk_rise = aclk_lvl && !state_q.aclk_prev;
      state_d.aclk_prev = aclk_lvl;
      state_d.async_o.tx_tick = state_q.e_fsel[PIN_E_CLK] && aclk_rise &&
                                state_q.ctrl[CTRL_ACLK_TX];
      state_d.async_o.rx_tick = state_q.e_fsel[PIN_E_CLK] && aclk_rise &&
                                state_q.ctrl[CTRL_ACLK_RX];
      // Receive data into the async unit; idle line reads high
      state_d.async_o.rx_bit  = !state_q.e_fsel[PIN_E_RX] ||
                                e_lvl[PIN_E_RX];

      // ----------------------------------------------------------------
      // Pin drive
      // ----------------------------------------------------------------
      // Registered, so a pin follows its cause one cycle later
      // GPIO direction and data for ports D and E
      state_d.d_pin.oe = state_q.d_dir;
      state_d.d_pin.o  = state_q.d_data;
      state_d.e_pin.oe = state_q.e_dir;
      state_d.e_pin.o  = state_q.e_data;

      // Serial role overrides the GPIO direction bit
      if (state_q.d_fsel[PIN_D_CLK]) begin
         state_d.d_pin.oe[PIN_D_CLK] = state_q.ctrl[CTRL_SCLK_OUT];
         state_d.d_pin.o[PIN_D_CLK]  = sync_unit_i.clk_gen;
      end
      if (state_q.d_fsel[PIN_D_RX]) begin
         state_d.d_pin.oe[PIN_D_RX] = 1'b0;
         state_d.d_pin.o[PIN_D_RX]  = 1'b0;
      end
      // Transmit pin drives only while sending
      if (state_q.d_fsel[PIN_D_TX]) begin
         state_d.d_pin.oe[PIN_D_TX] = sync_unit_i.tx_active;
         state_d.d_pin.o[PIN_D_TX]  = sync_unit_i.tx_bit;
      end
      // Async receive pin is input only
      if (state_q.e_fsel[PIN_E_RX]) begin
         state_d.e_pin.oe[PIN_E_RX] = 1'b0;
         state_d.e_pin.o[PIN_E_RX]  = 1'b0;
      end
      if (state_q.e_fsel[PIN_E_TX]) begin
         state_d.e_pin.oe[PIN_E_TX] = 1'b1;
         state_d.e_pin.o[PIN_E_TX]  = async_unit_i.tx_bit;
      end
      // Async clock pin direction from control
      if (state_q.e_fsel[PIN_E_CLK]) begin
         state_d.e_pin.oe[PIN_E_CLK] = state_q.ctrl[CTRL_ACLK_OUT];
         state_d.e_pin.o[PIN_E_CLK]  = async_unit_i.clk_gen;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q            <= '0;
         // All pins come up as GPIO inputs
         state_q.d_fsel     <= RST_FSEL;
         state_q.e_fsel     <= RST_FSEL;
         state_q.d_dir      <= RST_DIR;
         state_q.e_dir      <= RST_DIR;
         state_q.d_data     <= RST_DATA;
         state_q.e_data     <= RST_DATA;
         state_q.ctrl       <= RST_CTRL;
         // Idle line reads high, so the unit sees no false start bit
         state_q.async_o.rx_bit <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign prdata       = state_q.prdata;
   assign pready       = state_q.pready;
   assign pslverr      = state_q.pslverr;
   assign port_d_pin   = state_q.d_pin;
   assign port_e_pin   = state_q.e_pin;
   assign sync_unit_o  = state_q.sync_o;
   assign async_unit_o = state_q.async_o;

endmodule // spm_pin_mux

// [testbench/spm_checker.sv]
// Checker: port-level properties of the serial pin mux
`timescale 1ns/1ns
module spm_checker
   import spm_pkg::*;
(
   input logic              pclk,
   input logic              presetn,
   input logic              psel,
   input logic              penable,
   input logic              pwrite,
   input logic [7:0]        paddr,
   input logic [31:0]       pwdata,
   input logic [31:0]       prdata,
   input logic              pready,
   input logic              pslverr,
   input logic [2:0]        port_d_pin_i,
   input spm_pins_type      port_d_pin,
   input logic [2:0]        port_e_pin_i,
   input spm_pins_type      port_e_pin,
   input spm_sync_in_type   sync_unit_i,
   input spm_sync_out_type  sync_unit_o,
   input spm_async_in_type  async_unit_i,
   input spm_async_out_type async_unit_o
);
   // ------------------------------------------------------------
   // Shadow of written registers
   // ------------------------------------------------------------
   logic [4:0] sh_q [0:6];
   logic       wr_en;
   logic [2:0] eoe_d, eo_d, eoe_e, eo_e;
   assign wr_en = psel & penable & pready & pwrite & paddr[4:2] != 3'h7
                  & paddr[7:5] == 3'h0 & paddr[1:0] == 2'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 7; i++) sh_q[i] <= 5'h00;
      end else if (wr_en) begin
         sh_q[paddr[4:2]] <= pwdata[4:0];
      end
   end
   // Serial role overrides the direction bit
   always_comb begin
      eoe_d = sh_q[1][2:0] & ~sh_q[0][2:0];
      eo_d = sh_q[2][2:0];
      eoe_e = sh_q[4][2:0] & ~sh_q[3][2:0];
      eo_e = sh_q[5][2:0];
      if (sh_q[0][0]) begin
         eoe_d[0] = sh_q[6][1];
         eo_d[0] = sync_unit_i.clk_gen;
      end
      if (sh_q[0][2]) begin
         eoe_d[2] = sync_unit_i.tx_active;
         eo_d[2] = sync_unit_i.tx_bit;
      end
      if (sh_q[3][1]) begin
         eoe_e[1] = 1'b1;
         eo_e[1] = async_unit_i.tx_bit;
      end
      if (sh_q[3][2]) begin
         eoe_e[2] = sh_q[6][2];
         eo_e[2] = async_unit_i.clk_gen;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready too long");
   AST_ERR_READY: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("pslverr alone");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero");
   AST_RESET_GPIO: assert property ($rose(presetn) |->
      port_d_pin.oe == 3'h0 && port_e_pin.oe == 3'h0)
      else $error("pin driven after reset");
   AST_D_PINS: assert property (port_d_pin.oe == $past(eoe_d) &&
      (port_d_pin.o & port_d_pin.oe) == $past(eo_d & eoe_d))
      else $error("port d pin mismatch");
   AST_E_PINS: assert property (port_e_pin.oe == $past(eoe_e) &&
      (port_e_pin.o & port_e_pin.oe) == $past(eo_e & eoe_e))
      else $error("port e pin mismatch");
   AST_SYNC_RX: assert property (sh_q[0][1] && $past(sh_q[0][1], 3) |->
      sync_unit_o.rx_bit == $past(port_d_pin_i[1], 3))
      else $error("sync rx bit wrong");
   AST_ASYNC_RX_IDLE: assert property (!sh_q[3][0] &&
      !$past(sh_q[3][0]) |-> async_unit_o.rx_bit)
      else $error("async rx not idle");
   AST_ASYNC_RX: assert property (sh_q[3][0] && $past(sh_q[3][0], 3)
      |-> async_unit_o.rx_bit == $past(port_e_pin_i[0], 3))
      else $error("async rx bit wrong");
   AST_RX_SAMPLE_MODE: assert property (sync_unit_o.rx_sample |->
      sh_q[6][0] || $past(sh_q[6][0]))
      else $error("rx sample in async mode");
   cover property (sync_unit_o.rx_sample);
   cover property (async_unit_o.tx_tick);
   cover property (pslverr);
endmodule // spm_checker

// [testbench/spm_far_side.sv]
// Far-side serial devices: bit clock source and data lines
`timescale 1ns/1ns
module spm_far_side (
   output logic [2:0] d_far,
   output logic [2:0] e_far
);
   logic sclk = 1'b0;
   logic rxd = 1'b0;
   logic rxa = 1'b1;
   logic noise = 1'b0;
   // Undriven transmit lines must never look stable
   always #35 noise = ~noise;
   assign d_far = {noise, rxd, sclk};
   assign e_far = {sclk, noise, rxa};
   // ------------------------------------------------------------
   // Frame: clock stands low outside it
   // ------------------------------------------------------------
   task automatic send_frame(input int bits, input int half_ns);
      #13;
      for (int i = 0; i < bits; i++) begin
         rxd = 1'($urandom);
         rxa = 1'($urandom);
         #(half_ns);
         sclk = 1'b1;
         #(half_ns);
         sclk = 1'b0;
      end
   endtask
endmodule // spm_far_side

// [testbench/test_spm_pin_mux.sv]
// Testbench: register, pin and frame scenarios for the pin mux
`timescale 1ns/1ns
module test_spm_pin_mux;
   import spm_pkg::*;
   logic              pclk = 1'b0;
   logic              presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [2:0]        d_i, e_i, d_far, e_far, fd, dd, vd, fe, de, ve, m;
   logic [4:0]        c;
   spm_pins_type      d_pin, e_pin;
   spm_sync_in_type   s_i = '0;
   spm_sync_out_type  s_o;
   spm_async_in_type  a_i = '0;
   spm_async_out_type a_o;
   int                bad_count, checks;
   int                cnt [4] = '{default: 0};
   int                c0 [4];
   logic [4:0]        cv [2] = '{5'h19, 5'h08};
   spm_pin_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_d_pin_i(d_i), .port_d_pin(d_pin), .port_e_pin_i(e_i),
      .port_e_pin(e_pin), .sync_unit_i(s_i), .sync_unit_o(s_o),
      .async_unit_i(a_i), .async_unit_o(a_o));
   spm_far_side far (.d_far(d_far), .e_far(e_far));
   // Wire level: design drive wins where enabled
   assign d_i = (d_pin.oe & d_pin.o) | (~d_pin.oe & d_far);
   assign e_i = (e_pin.oe & e_pin.o) | (~e_pin.oe & e_far);
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      s_i <= 3'($urandom);
      a_i <= 2'($urandom);
      cnt[0] += int'(s_o.tx_shift === 1'b1);
      cnt[1] += int'(s_o.rx_sample === 1'b1);
      cnt[2] += int'(a_o.tx_tick === 1'b1);
      cnt[3] += int'(a_o.rx_tick === 1'b1);
   end
   // ------------------------------------------------------------
   // Tasks and expectations
   // ------------------------------------------------------------
   task automatic test_done();
      $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         test_done();
      end
   endtask
   function automatic logic [2:0] oe_d(logic [2:0] f, dr, logic [4:0] k);
      return {dr[2], ~f[1] & dr[1], f[0] ? k[1] : dr[0]};
   endfunction
   function automatic logic [2:0] oe_e(logic [2:0] f, dr, logic [4:0] k);
      return {f[2] ? k[2] : dr[2], f[1] | dr[1], ~f[0] & dr[0]};
   endfunction
   function automatic int exp_cnt(logic [4:0] k, int j);
      logic [3:0] on;
      on = {k[4], k[3], k[0], 1'b1};
      return on[j] ? 8 : 0;
   endfunction
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h3a2f1f8b));
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {bad_count, checks} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      check("reset_oe", {d_pin.oe, e_pin.oe}, 6'h00);
      for (int a = 0; a < 8; a++) begin
         apb(1'b0, 8'(a * 4), 32'h0);
         if (a != 2 && a != 5) check("reset_reg", rd & 32'h1f, 32'h0);
      end
      apb(1'b1, 8'h20, 32'hffffffff);
      check("unmapped_err", err, 1'b1);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped_rd", {err, rd}, {1'b1, 32'h0});
      $display("reset test done");
      for (int i = 0; i < 12; i++) begin
         {fd, dd, vd, fe, de, ve} = 18'($urandom);
         c = 5'($urandom) & 5'h06;
         if (i == 0) {fd, dd, fe, de} = 12'hfff;
         if (i == 1) {fd, fe} = 6'h00;
         apb(1'b1, OFS_D_FSEL, 32'(fd));
         apb(1'b1, OFS_D_DIR, 32'(dd));
         apb(1'b1, OFS_D_DATA, 32'(vd));
         apb(1'b1, OFS_E_FSEL, 32'(fe));
         apb(1'b1, OFS_E_DIR, 32'(de));
         apb(1'b1, OFS_E_DATA, 32'(ve));
         apb(1'b1, OFS_CTRL, 32'(c));
         apb(1'b0, OFS_D_FSEL, 32'h0);
         check("d_fsel", rd, 32'(fd));
         apb(1'b0, OFS_E_DIR, 32'h0);
         check("e_dir", rd, 32'(de));
         m = {~fd[2], 2'h3};
         check("d_oe", d_pin.oe & m, oe_d(fd, dd, c) & m);
         check("e_oe", e_pin.oe, oe_e(fe, de, c));
         check("d_out", d_pin.o & dd & ~fd, vd & dd & ~fd);
         check("e_out", e_pin.o & de & ~fe, ve & de & ~fe);
         apb(1'b0, OFS_D_DATA, 32'h0);
         check("d_lvl", rd & 32'(dd & ~fd), 32'(vd & dd & ~fd));
      end
      $display("gpio test done");
      // Clocks back to the pins and the flag cleared before counting
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_D_FSEL, 32'h7);
      apb(1'b1, OFS_E_FSEL, 32'h7);
      apb(1'b1, OFS_STATUS, 32'h1);
      foreach (cv[k]) begin
         apb(1'b1, OFS_CTRL, 32'(cv[k]));
         c0 = cnt;
         far.send_frame(8, 200);
         repeat (6) @(posedge pclk);
         for (int j = 0; j < 4; j++) begin
            check("edge_count", 32'(cnt[j] - c0[j]), 32'(exp_cnt(cv[k], j)));
         end
      end
      $display("frame test done");
      apb(1'b0, OFS_STATUS, 32'h0);
      check("no_viol", rd[STAT_VIOL], 1'b0);
      far.send_frame(4, 75);
      repeat (6) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("viol", rd[STAT_VIOL], 1'b1);
      apb(1'b1, OFS_STATUS, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("viol_clear", rd[STAT_VIOL], 1'b0);
      $display("clock check test done");
      test_done();
   end
endmodule // test_spm_pin_mux
bind spm_pin_mux spm_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .port_d_pin_i, .port_d_pin,
   .port_e_pin_i, .port_e_pin, .sync_unit_i, .sync_unit_o, .async_unit_i,
   .async_unit_o);
